// ### design/adc_ctl_pkg.sv
// shared constants and types for the converter control port
package adc_ctl_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_MIN_NS = 100;
  localparam int ACQ_MIN_NS    = 2500;
  localparam int SYNC_LAT      = 3;
  // least times round up to whole cycles
  localparam logic [7:0] STROBE_CYCLES =
    8'((STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT);
  localparam logic [7:0] CAL_PULSE_CYCLES =
    8'((STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACQ_CYCLES =
    8'((ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HOLD_CYCLES   = 8'h04;
  localparam logic [7:0] TRIG_HI_CYCLES = 8'h05;
  localparam int TRIG_START_MAX_X10 = 15;
  localparam logic [7:0] TRIG_START_CYCLES = 8'(TRIG_START_MAX_X10 / 10);
  localparam logic [7:0] CONV_CYCLES   = 8'h11;
  localparam logic [7:0] CAL_CYCLES    = 8'hA0;
  localparam logic [7:0] PD_CAL_CONV_MAX = 8'hB9;
  localparam logic [7:0] CNT_SAT       = 8'hFF;
  // ==========================================================
  // control/status register layout
  localparam int BIT_LATCHED = 0;
  localparam int BIT_CAL     = 1;
  localparam int BIT_HOLD    = 2;
  localparam int BIT_PD      = 3;
  localparam int BIT_RSVD    = 4;
  localparam int BIT_SUPPLY  = 5;
  localparam int BIT_CALERR  = 6;
  localparam int BIT_BUSY    = 7;
  localparam logic [7:0] CSR_RESET     = 8'h00;
  localparam logic [7:0] CSR_WR_MASK   = 8'h2F;
  localparam logic [7:0] BUS_IDLE      = 8'hFF;
  // ==========================================================
  // host commands and states
  localparam logic [1:0] CMD_READ  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_TRIG  = 2'h2;
  localparam logic [1:0] CMD_CAL   = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_CAL, ST_CONV} dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_ACCESS, H_RELEASE, H_TRIG, H_CAL} host_state_t;
endpackage

// ### design/adc_bus_if.sv
// parallel port and trigger pin between converter and microprocessor
`timescale 1ns/1ps
interface adc_bus_if;
  logic       cs_b;
  logic       rd_b;
  logic       wr_b;
  logic       register_select;
  logic       high_byte_select;
  logic       channel_select_lo;
  logic       channel_select_hi;
  logic [7:0] data_host;
  logic       data_host_oe;
  logic [7:0] data_dev;
  logic       data_dev_oe;
  logic [7:0] data_bus;
  logic       hold_trigger;
  logic       busy_b;
  // resolved bus, pulled high when nobody drives
  assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'hFF);
  modport device (
    input  cs_b, rd_b, wr_b, register_select, high_byte_select,
    input  channel_select_lo, channel_select_hi, data_bus, hold_trigger,
    output data_dev, data_dev_oe, busy_b
  );
  modport host (
    output cs_b, rd_b, wr_b, register_select, high_byte_select,
    output channel_select_lo, channel_select_hi, data_host, data_host_oe,
    output hold_trigger,
    input  data_bus, busy_b
  );
endinterface

// ### design/adc_ctl_device.sv
// converter end: control/status register, sequencing and port answer
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] read with both selects high returns status
// [RULE_02] write with both selects high loads, converts
// [RULE_03] internal strobes are NOR of select, strobe
// [RULE_04] status bit order fixed D0 to D7
// [RULE_05] host avoids register read with byte-select low
// [RULE_06] supply loss sets flag, calibrates, clears controls
// [RULE_07] write with D5 low clears supply flag
// [RULE_08] overflow flag set in calibration, cleared at start
// [RULE_09] D0 latched output, D2 hold trigger mode
// [RULE_10] D1 high starts calibration, reads busy
// [RULE_11] host writes D4, D6, D7 low
// [RULE_12] D3 high powers down, registers stay reachable
// [RULE_13] power down left by D3 low, pin, D1
// [RULE_14] write strobe in power down converts once
// [RULE_15] D1 and D3 calibrate, convert within 185
// [RULE_16] waking adds no cycles to conversion
// [RULE_17] trigger rise starts conversion within 1.5 cycles
// [RULE_18] host holds trigger low 2.5 us minimum
// [RULE_19] host aligns trigger edge after clock fall; the host here changes the pin on the rising clock edge
// [RULE_20] hold mode write latches channel, no conversion
// [RULE_21] host settles channel 2.5 us before trigger
// [RULE_22] latched mode updates result only at completion
// [RULE_23] busy low while busy, starts then ignored
// [RULE_24] strobes synchronised before use
module adc_ctl_device
  import adc_ctl_pkg::*;
(
  input  wire logic   clk,            // converter clock
  input  wire logic   rst_b,          // synchronous reset, active low
  adc_bus_if.device   bus,            // parallel port and pin
  input  wire logic   supply_loss,    // pulse: supply fell and recovered
  input  wire logic   cal_overflow,   // pulse: overflow in calibration
  input  wire logic [11:0] conv_result, // successive approximation value
  output logic [11:0] result,         // output register contents
  output logic [1:0]  channel,        // latched input channel
  output logic        power_down,     // analog and clock stopped
  output logic        sample_hold     // high: pin drives hold timing
);
  // ==========================================================
  // state
  typedef struct packed {
    dev_state_t  st;
    logic [7:0]  cnt;
    logic [1:0]  s1;
    logic [1:0]  s2;
    logic [1:0]  s3;
    logic [7:0]  wdata;
    logic        wsel;
    logic [1:0]  wch;
    logic        pin_q;
    logic        latched;
    logic        hold;
    logic        pd;
    logic        supply;
    logic        calerr;
    logic        conv_pend;
    logic [11:0] result;
    logic [7:0]  dout;
    logic        doe;
    logic        busy_b;
    logic [1:0]  channel;
    logic        pwr_dn;
  } dev_reg_t;

  dev_reg_t q;
  dev_reg_t d;

  function automatic logic [7:0] csr_pack(input dev_reg_t r);
    logic [7:0] v;
    v = CSR_RESET;
    v[BIT_LATCHED] = r.latched;
    v[BIT_CAL]     = (r.st == ST_CAL);
    v[BIT_HOLD]    = r.hold;
    v[BIT_PD]      = r.pd;
    v[BIT_RSVD]    = 1'b0;
    v[BIT_SUPPLY]  = r.supply;
    v[BIT_CALERR]  = r.calerr;
    v[BIT_BUSY]    = (r.st != ST_IDLE);
    return v;
  endfunction

  // ==========================================================
  // next state
  logic rd_on;
  logic wr_end;
  logic trig_rise;
  logic cal_req;
  logic start_cal;
  logic start_conv;

  always_comb begin
    d = q;
    // only s2 and s3 are looked at, s1 is metastability guard
    d.s1 = {~(bus.cs_b | bus.wr_b), ~(bus.cs_b | bus.rd_b)};  // see [RULE_03] [RULE_24]
    d.s2 = q.s1;
    d.s3 = q.s2;
    rd_on  = q.s2[0];
    wr_end = q.s3[1] & ~q.s2[1];  // see [RULE_24]
    // pin is synchronous: one flop keeps the trigger inside 1.5 cycles
    d.pin_q   = bus.hold_trigger;
    trig_rise = q.hold & bus.hold_trigger & ~q.pin_q;  // see [RULE_17]
    cal_req   = ~q.hold & ~bus.hold_trigger & q.pin_q;
    start_cal  = 1'b0;
    start_conv = trig_rise;
    // data keeps being sampled while the write pulse lasts
    if (q.s2[1]) begin
      d.wdata = bus.data_bus;
      d.wsel  = bus.register_select & bus.high_byte_select;
      d.wch   = {bus.channel_select_hi, bus.channel_select_lo};
    end
    if (wr_end) begin
      d.channel = q.wch;  // see [RULE_20]
      if (q.wsel) begin
        d.latched = q.wdata[BIT_LATCHED];  // see [RULE_02] [RULE_09]
        d.hold    = q.wdata[BIT_HOLD];     // see [RULE_09]
        d.pd      = q.wdata[BIT_PD];       // see [RULE_12] [RULE_13] [RULE_15]
        if (!q.wdata[BIT_SUPPLY]) begin
          d.supply = 1'b0;  // see [RULE_07]
        end
        start_cal = q.wdata[BIT_CAL];  // see [RULE_10] [RULE_13]
      end
      if (!q.hold) begin
        start_conv = 1'b1;  // see [RULE_02] [RULE_14] [RULE_20]
      end
    end
    if (cal_req) begin
      start_cal = 1'b1;
      d.pd      = 1'b0;  // see [RULE_13]
    end
    if (supply_loss) begin
      d.supply  = 1'b1;  // see [RULE_06]
      d.latched = 1'b0;
      d.hold    = 1'b0;
      d.pd      = 1'b0;
    end
    // sequencer: busy ignores starts; supply loss overrides
    if (supply_loss) begin
      d.st        = ST_CAL;  // see [RULE_06]
      d.cnt       = CAL_CYCLES - 8'h01;
      d.calerr    = 1'b0;
      d.conv_pend = 1'b0;
    end else begin
      case (q.st)
        ST_IDLE: begin
          if (start_cal) begin
            d.st        = ST_CAL;  // see [RULE_10] [RULE_15]
            d.cnt       = CAL_CYCLES - 8'h01;
            d.calerr    = 1'b0;  // see [RULE_08]
            d.conv_pend = start_conv;
          end else if (start_conv) begin
            // same length awake or powered down
            d.st  = ST_CONV;  // see [RULE_14] [RULE_16]
            d.cnt = CONV_CYCLES - 8'h01;
          end
        end
        ST_CAL: begin
          if (q.cnt == 8'h00) begin
            d.st        = q.conv_pend ? ST_CONV : ST_IDLE;  // see [RULE_15]
            d.cnt       = CONV_CYCLES - 8'h01;
            d.conv_pend = 1'b0;
          end else begin
            d.cnt = q.cnt - 8'h01;  // see [RULE_23]
          end
        end
        ST_CONV: begin
          if (q.cnt == 8'h00) begin
            d.st = ST_IDLE;
            if (q.latched) begin
              d.result = conv_result;  // see [RULE_22]
            end
          end else begin
            d.cnt = q.cnt - 8'h01;  // see [RULE_23]
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end
    if (!q.latched) begin
      d.result = conv_result;
    end
    // set after any clear so an overflow is never dropped
    if (cal_overflow && q.st == ST_CAL) begin
      d.calerr = 1'b1;  // see [RULE_08]
    end
    d.busy_b = (d.st == ST_IDLE);  // see [RULE_23]
    // pd keeps its bit, so a single conversion falls back asleep
    d.pwr_dn = d.pd & (d.st == ST_IDLE);  // see [RULE_12] [RULE_14]
    d.doe = rd_on;
    if (bus.register_select) begin
      d.dout = bus.high_byte_select ? csr_pack(q) : 8'h00;  // see [RULE_01] [RULE_04]
    end else begin
      d.dout = bus.high_byte_select ? {4'h0, q.result[11:8]} : q.result[7:0];
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q        <= '0;
      q.st     <= ST_IDLE;
      q.busy_b <= 1'b1;
      q.pin_q  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.data_dev    = q.dout;
  assign bus.data_dev_oe = q.doe;
  assign bus.busy_b      = q.busy_b;
  assign result          = q.result;
  assign channel         = q.channel;
  assign power_down      = q.pwr_dn;
  assign sample_hold     = q.hold;

endmodule // adc_ctl_device

// ### design/adc_ctl_host.sv
// microprocessor end: strobe sequencing and trigger pin pacing
`timescale 1ns/1ps
module adc_ctl_host
  import adc_ctl_pkg::*;
(
  input  wire logic       clk,          // system clock
  input  wire logic       rst_b,        // synchronous reset, active low
  adc_bus_if.host         bus,          // parallel port and pin
  input  wire logic       req_valid,    // request present
  input  wire logic [1:0] req_kind,     // read, write, trigger, calibrate
  input  wire logic       req_rs,       // register select
  input  wire logic       req_hb_sel,   // high byte select
  input  wire logic [7:0] req_data,     // write data
  input  wire logic [1:0] req_channel,  // channel for writes
  output logic            req_ready,    // idle, request taken
  output logic            resp_valid,   // one-cycle completion
  output logic [7:0]      resp_data,    // read data
  output logic            resp_err,     // request refused
  output logic            dev_busy      // converter busy seen
);
  // ==========================================================
  // state
  typedef struct packed {
    host_state_t st;
    logic [7:0]  cnt;
    logic        cs_b;
    logic        rd_b;
    logic        wr_b;
    logic        rs;
    logic        hb_sel;
    logic [1:0]  ch;
    logic [7:0]  dout;
    logic        doe;
    logic        pin;
    logic        hold_mode;
    logic [7:0]  low_cnt;
    logic [7:0]  ch_cnt;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        rerr;
    logic        ready;
    logic        is_wr;
    logic        busy;
  } host_reg_t;

  host_reg_t q;
  host_reg_t d;

  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.busy   = ~bus.busy_b;
    if (!q.pin && q.low_cnt != CNT_SAT) begin
      d.low_cnt = q.low_cnt + 8'h01;
    end
    if (q.ch_cnt != CNT_SAT) begin
      d.ch_cnt = q.ch_cnt + 8'h01;
    end
    case (q.st)
      H_IDLE: begin
        if (req_valid) begin
          d.rerr = 1'b0;
          if (req_kind == CMD_READ || req_kind == CMD_WRITE) begin
            if (req_rs && !req_hb_sel) begin
              d.rerr   = 1'b1;  // see [RULE_05] [RULE_11]
              d.rvalid = 1'b1;
            end else begin
              d.is_wr = (req_kind == CMD_WRITE);
              d.rs    = req_rs;
              d.hb_sel = req_hb_sel;
              d.cs_b  = 1'b0;
              d.rd_b  = (req_kind == CMD_WRITE);  // see [RULE_01]
              d.wr_b  = (req_kind != CMD_WRITE);  // see [RULE_02]
              d.doe   = (req_kind == CMD_WRITE);
              d.dout  = req_data & CSR_WR_MASK;  // see [RULE_11]
              d.cnt   = STROBE_CYCLES - 8'h01;
              d.st    = H_ACCESS;
              if (req_kind == CMD_WRITE && req_channel != q.ch) begin
                d.ch     = req_channel;
                d.ch_cnt = 8'h00;
              end
            end
          end else if ((req_kind == CMD_TRIG) != q.hold_mode) begin
            d.rerr   = 1'b1;
            d.rvalid = 1'b1;
          end else if (req_kind == CMD_TRIG) begin
            d.st = H_TRIG;
          end else begin
            d.pin = 1'b0;
            d.cnt = CAL_PULSE_CYCLES - 8'h01;
            d.st  = H_CAL;
          end
        end
      end
      H_ACCESS: begin
        if (q.cnt == 8'h00) begin
          d.cs_b  = 1'b1;
          d.rd_b  = 1'b1;
          d.wr_b  = 1'b1;
          d.rdata = bus.data_bus;
          d.cnt   = HOLD_CYCLES - 8'h01;
          d.st    = H_RELEASE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      H_RELEASE: begin
        if (q.cnt == 8'h00) begin
          d.doe    = 1'b0;
          d.rvalid = 1'b1;
          d.st     = H_IDLE;
          if (q.is_wr && q.rs && q.hb_sel) begin
            d.hold_mode = q.dout[BIT_HOLD];
            // pin idles low in hold mode, high otherwise
            d.pin = ~q.dout[BIT_HOLD];
            if (q.dout[BIT_HOLD]) begin
              d.low_cnt = 8'h00;
            end
          end
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      H_TRIG: begin
        if (!q.pin) begin
          if (q.low_cnt >= ACQ_CYCLES && q.ch_cnt >= ACQ_CYCLES) begin
            d.pin = 1'b1;  // see [RULE_18] [RULE_21]
            d.cnt = TRIG_HI_CYCLES - 8'h01;
          end
        end else if (q.cnt == 8'h00) begin
          d.pin     = 1'b0;
          d.low_cnt = 8'h00;
          d.rvalid  = 1'b1;
          d.st      = H_IDLE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      H_CAL: begin
        if (q.cnt == 8'h00) begin
          d.pin    = 1'b1;
          d.rvalid = 1'b1;
          d.st     = H_IDLE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase
    d.ready = (d.st == H_IDLE) && !(q.st == H_IDLE && req_valid);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q       <= '0;
      q.st    <= H_IDLE;
      q.cs_b  <= 1'b1;
      q.rd_b  <= 1'b1;
      q.wr_b  <= 1'b1;
      q.pin   <= 1'b1;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bus.cs_b              = q.cs_b;
  assign bus.rd_b              = q.rd_b;
  assign bus.wr_b              = q.wr_b;
  assign bus.register_select   = q.rs;
  assign bus.high_byte_select  = q.hb_sel;
  assign bus.channel_select_lo = q.ch[0];
  assign bus.channel_select_hi = q.ch[1];
  assign bus.data_host         = q.dout;
  assign bus.data_host_oe      = q.doe;
  assign bus.hold_trigger      = q.pin;
  assign req_ready             = q.ready;
  assign resp_valid            = q.rvalid;
  assign resp_data             = q.rdata;
  assign resp_err              = q.rerr;
  assign dev_busy              = q.busy;

endmodule // adc_ctl_host

// ### verification/adc_ctl_assertions.sv
// concurrent checks on the converter port signals
`timescale 1ns/1ps
module adc_ctl_assertions
  import adc_ctl_pkg::*;
(
  input wire logic       clk,              // clock
  input wire logic       rst_b,            // reset, active low
  input wire logic       cs_b,             // chip select
  input wire logic       rd_b,             // read strobe
  input wire logic       wr_b,             // write strobe
  input wire logic       register_select,  // register select
  input wire logic       high_byte_select, // byte select
  input wire logic [7:0] data_bus,         // resolved bus
  input wire logic       data_host_oe,     // host drives
  input wire logic [7:0] data_dev,         // device data
  input wire logic       data_dev_oe,      // device drives
  input wire logic       hold_trigger,     // pin 26
  input wire logic       busy_b            // busy, active low
);
  logic hold_q;
  // =========================================================
  // hold mode as it stood before each register write
  // taken at the strobe rise, so the write's own edge still sees the old mode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_q <= 1'b0;
    end else if ($rose(wr_b) && register_select && high_byte_select) begin
      hold_q <= data_bus[BIT_HOLD];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // =========================================================
  // assertions
  AST_WR_WIDTH: assert property ($fell(wr_b) |-> !wr_b [*5])
    else $error("write strobe too short");
  AST_CS_WITH_STROBE: assert property ((!wr_b || !rd_b) |-> !cs_b)
    else $error("strobe without chip select");
  AST_NO_CONTENTION: assert property (!(data_dev_oe && data_host_oe))
    else $error("both ends drive the bus");
  AST_OE_NEEDS_READ: assert property ($rose(data_dev_oe) |-> $past(!cs_b && !rd_b, 2))
    else $error("device drives without read");
  AST_OE_RELEASE: assert property ($rose(rd_b) |-> ##[1:6] !data_dev_oe)
    else $error("device holds bus after read");
  AST_RSVD_ZERO: assert property (data_dev_oe && register_select && high_byte_select
    |-> !data_dev[BIT_RSVD])
    else $error("reserved status bit set");
  AST_WRITE_STARTS: assert property ($rose(wr_b) && busy_b && !hold_q
    |-> ##[1:5] !busy_b)
    else $error("write did not start conversion");
  AST_HOLD_NO_START: assert property ($rose(wr_b) && busy_b && hold_q
    |-> busy_b [*6])
    else $error("write started conversion in hold mode");
  AST_TRIG_START: assert property (hold_q && $rose(hold_trigger) && busy_b
    |-> ##[0:1] !busy_b)
    else $error("trigger start late");
  AST_BUSY_MIN: assert property ($fell(busy_b) |-> !busy_b [*8])
    else $error("busy too short");
  AST_ACQ_LOW: assert property (hold_q && $fell(hold_trigger)
    |-> !hold_trigger [*8])
    else $error("trigger low too short");
  cover property ($rose(data_dev_oe));
  cover property (hold_q && $rose(hold_trigger));
  cover property ($fell(busy_b) ##1 !busy_b [*8]);
endmodule // adc_ctl_assertions

// ### verification/adc_control_status_register_logic_bench.sv
// bench: host and converter ends joined by the port
`timescale 1ns/1ps
module adc_control_status_register_logic_bench
  import adc_ctl_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b, supply_loss, cal_overflow, req_valid, req_rs, req_hb_sel;
  logic        power_down, sample_hold, req_ready, resp_valid, resp_err, dev_busy;
  logic [11:0] conv_result, result;
  logic [1:0]  channel, req_kind, req_channel;
  logic [7:0]  req_data, resp_data;
  int          error_cnt = 0;
  int          check_count = 0;
  int          c0, c1;

  always #10 clk = ~clk;
  adc_bus_if adc_bus_if_i ();
  adc_ctl_device adc_ctl_device_i (.clk, .rst_b, .bus(adc_bus_if_i), .supply_loss,
    .cal_overflow, .conv_result, .result, .channel, .power_down, .sample_hold);
  adc_ctl_host adc_ctl_host_i (.clk, .rst_b, .bus(adc_bus_if_i), .req_valid, .req_kind,
    .req_rs, .req_hb_sel, .req_data, .req_channel, .req_ready, .resp_valid, .resp_data,
    .resp_err, .dev_busy);
  adc_ctl_assertions adc_ctl_assertions_i (.clk, .rst_b,
    .cs_b(adc_bus_if_i.cs_b), .rd_b(adc_bus_if_i.rd_b), .wr_b(adc_bus_if_i.wr_b),
    .register_select(adc_bus_if_i.register_select),
    .high_byte_select(adc_bus_if_i.high_byte_select),
    .data_bus(adc_bus_if_i.data_bus), .data_host_oe(adc_bus_if_i.data_host_oe),
    .data_dev(adc_bus_if_i.data_dev), .data_dev_oe(adc_bus_if_i.data_dev_oe),
    .hold_trigger(adc_bus_if_i.hold_trigger), .busy_b(adc_bus_if_i.busy_b));
  // =========================================================
  // shared tasks
  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic hang(input string n);
    error_cnt++;
    $display("MISMATCH %s expected done seen timeout", n);
    give_verdict();
  endtask
  task automatic op(input logic [1:0] k, input logic rs, hb, input logic [7:0] d,
                    input logic [1:0] ch);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req_kind = k;
    req_rs = rs;
    req_hb_sel = hb;
    req_data = d;
    req_channel = ch;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) hang("ready");
    // the request is taken at the rising edge in between
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) hang("response");
  endtask
  // busy may not have fallen yet, so allow a short lead-in before counting
  task automatic wait_done(output int c);
    int n;
    n = 0;
    c = 0;
    while (adc_bus_if_i.busy_b !== 1'b0 && n < 10) begin
      @(negedge clk);
      n++;
    end
    while (adc_bus_if_i.busy_b !== 1'b1 && c < 400) begin
      @(negedge clk);
      c++;
    end
    if (c >= 400) hang("busy");
  endtask
  task automatic csr_is(input logic [7:0] e);
    op(CMD_READ, 1'b1, 1'b1, 8'h00, 2'h0);
    chk("status", {4'h0, e}, {4'h0, resp_data});
  endtask
  task automatic pulse_in(input logic sup);
    @(negedge clk);
    if (sup) supply_loss = 1'b1;
    else cal_overflow = 1'b1;
    @(negedge clk);
    supply_loss = 1'b0;
    cal_overflow = 1'b0;
  endtask
  // =========================================================
  // scenarios
  task automatic t_basic();
    csr_is(8'h00);
    conv_result = 12'hA5C;
    op(CMD_WRITE, 1'b1, 1'b1, 8'h01, 2'h0);
    csr_is(8'h81);
    wait_done(c0);
    csr_is(8'h01);
    op(CMD_READ, 1'b0, 1'b0, 8'h00, 2'h0);
    chk("low_byte", 12'h05C, {4'h0, resp_data});
    op(CMD_READ, 1'b0, 1'b1, 8'h00, 2'h0);
    chk("high_byte", 12'h00A, {4'h0, resp_data});
    conv_result = 12'h456;
    op(CMD_WRITE, 1'b0, 1'b1, 8'h00, 2'h1);
    chk("held", 12'hA5C, result);
    wait_done(c0);
    chk("updated", 12'h456, result);
    chk("channel", 12'h001, {10'h0, channel});
    op(CMD_WRITE, 1'b1, 1'b1, 8'h00, 2'h0);
    wait_done(c0);
    conv_result = 12'h789;
    @(negedge clk);
    @(negedge clk);
    chk("transparent", 12'h789, result);
  endtask
  task automatic t_cal();
    op(CMD_WRITE, 1'b1, 1'b1, 8'h02, 2'h0);
    csr_is(8'h82);
    pulse_in(1'b0);
    wait_done(c0);
    csr_is(8'h40);
    op(CMD_WRITE, 1'b1, 1'b1, 8'h02, 2'h0);
    csr_is(8'h82);
    wait_done(c0);
    csr_is(8'h00);
  endtask
  task automatic t_supply();
    op(CMD_WRITE, 1'b1, 1'b1, 8'h09, 2'h0);
    wait_done(c0);
    pulse_in(1'b1);
    wait_done(c0);
    csr_is(8'h20);
    chk("pd_cleared", 12'h000, {11'h0, power_down});
    op(CMD_WRITE, 1'b1, 1'b1, 8'h00, 2'h0);
    wait_done(c0);
    csr_is(8'h00);
  endtask
  task automatic t_pd();
    op(CMD_WRITE, 1'b1, 1'b1, 8'h08, 2'h0);
    wait_done(c0);
    chk("pd_on", 12'h001, {11'h0, power_down});
    csr_is(8'h08);
    op(CMD_WRITE, 1'b0, 1'b1, 8'h00, 2'h2);
    wait_done(c1);
    chk("pd_single", 12'h001, {11'h0, power_down});
    chk("conv_len", 12'(c0), 12'(c1));
    // count starts one cycle after busy falls
    chk("conv_cycles", 12'(CONV_CYCLES) - 12'h001, 12'(c1));
    conv_result = 12'h3C3;
    op(CMD_WRITE, 1'b1, 1'b1, 8'h0A, 2'h0);
    wait_done(c1);
    // c1 starts at resp_valid, which trails the strobe rise by HOLD_CYCLES
    chk("pd_cal_len", 12'h001, {11'h0, (c1 + HOLD_CYCLES <= PD_CAL_CONV_MAX)});
    chk("pd_result", 12'h3C3, result);
    chk("pd_back", 12'h001, {11'h0, power_down});
    op(CMD_CAL, 1'b0, 1'b0, 8'h00, 2'h0);
    wait_done(c1);
    chk("pd_pin_exit", 12'h000, {11'h0, power_down});
    op(CMD_WRITE, 1'b1, 1'b1, 8'h08, 2'h0);
    wait_done(c1);
    op(CMD_WRITE, 1'b1, 1'b1, 8'h00, 2'h0);
    wait_done(c1);
    chk("pd_write_exit", 12'h000, {11'h0, power_down});
  endtask
  task automatic t_hold();
    op(CMD_WRITE, 1'b1, 1'b1, 8'h04, 2'h0);
    wait_done(c0);
    chk("hold_on", 12'h001, {11'h0, sample_hold});
    op(CMD_WRITE, 1'b0, 1'b1, 8'h00, 2'h3);
    chk("hold_channel", 12'h003, {10'h0, channel});
    chk("hold_idle", 12'h001, {11'h0, adc_bus_if_i.busy_b});
    op(CMD_TRIG, 1'b0, 1'b0, 8'h00, 2'h0);
    chk("trig_ok", 12'h000, {11'h0, resp_err});
    chk("trig_busy", 12'h001, {11'h0, dev_busy});
    wait_done(c0);
    op(CMD_CAL, 1'b0, 1'b0, 8'h00, 2'h0);
    chk("cal_in_hold", 12'h001, {11'h0, resp_err});
    op(CMD_WRITE, 1'b1, 1'b1, 8'h00, 2'h0);
    wait_done(c0);
    chk("hold_off", 12'h000, {11'h0, sample_hold});
    op(CMD_TRIG, 1'b0, 1'b0, 8'h00, 2'h0);
    chk("trig_refused", 12'h001, {11'h0, resp_err});
  endtask
  task automatic t_refuse();
    op(CMD_READ, 1'b1, 1'b0, 8'h00, 2'h0);
    chk("rsvd_read", 12'h001, {11'h0, resp_err});
    op(CMD_WRITE, 1'b1, 1'b0, 8'hFF, 2'h0);
    chk("rsvd_write", 12'h001, {11'h0, resp_err});
    op(CMD_WRITE, 1'b1, 1'b1, 8'hD0, 2'h0);
    wait_done(c0);
    csr_is(8'h00);
  endtask
  // =========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    {supply_loss, cal_overflow, req_valid, req_rs, req_hb_sel} = 5'h00;
    {conv_result, req_kind, req_channel, req_data} = 24'h000000;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    t_basic();
    t_cal();
    t_supply();
    t_pd();
    t_hold();
    t_refuse();
    give_verdict();
  end
endmodule // adc_control_status_register_logic_bench
